// [design/parallel_host_bus_port.sv]
// Contract
// - mux select high means shared address/data lines; low means separate lines.
// - format select high means data strobe plus direction; low means read/write strobes.
// - one byte per access on eight data lines, reaching direct registers.
// - a byte takes about 260 ns separate, 300 ns multiplexed.
module parallel_host_bus_port
(
	input  wire logic                            clk,	// 40 MHz clock
	input  wire logic                            srst,	// sync reset, high
	input  wire logic [host_port_pkg::DATA_W-1:0] data_pin_i,	// data pins in
	output logic      [host_port_pkg::DATA_W-1:0] data_pin_o,	// data pins out
	output logic                                 data_pin_oe,	// data drive enable
	input  wire logic [host_port_pkg::ADDR_W-1:0] addr_pin,	// address pins
	input  wire logic                            cs_pin_n,	// chip select, low
	input  wire logic                            rd_pin_n,	// read or data strobe
	input  wire logic                            wr_pin_n,	// write strobe or direction
	input  wire logic                            ale_pin,	// latch or address strobe
	input  wire logic                            mux_select_pin,	// multiplexed mode strap
	input  wire logic                            bus_format_select_pin,	// format strap
	output logic      [host_port_pkg::ADDR_W-1:0] reg_addr,	// register address
	output logic      [host_port_pkg::DATA_W-1:0] reg_wdata,	// register write data
	output logic                                 reg_wr,	// write pulse
	output logic                                 reg_rd,	// read pulse
	input  wire logic [host_port_pkg::DATA_W-1:0] reg_rdata	// register read data
);
	import host_port_pkg::*;

	pin_sync_if sy ();

	pin_sync u_sync (
		.clk      (clk),
		.srst     (srst),
		.data_pin (data_pin_i),
		.addr_pin (addr_pin),
		.cs_pin_n (cs_pin_n),
		.rd_pin_n (rd_pin_n),
		.wr_pin_n (wr_pin_n),
		.ale_pin  (ale_pin),
		.mux_pin  (mux_select_pin),
		.fmt_pin  (bus_format_select_pin),
		.sy       (sy)
	);

	// --------------------------------
	// strobe decoding
	// --------------------------------
	logic       ale_d;
	logic [7:0] mux_addr;
	access_e    state;
	access_e    next_state;

	// format select picks the strobe meaning
	wire sel = ~sy.chip_sel_n;
	wire fmt_dir = sy.fmt_sel;
	wire rd_act = fmt_dir ? (~sy.rd_n & sy.wr_n) : (~sy.rd_n & sy.wr_n);
	wire wr_act = fmt_dir ? (~sy.rd_n & ~sy.wr_n) : (~sy.wr_n & sy.rd_n);
	wire rd_start = sel & rd_act;
	wire wr_start = sel & wr_act;
	wire strobe_idle = fmt_dir ? sy.rd_n : (sy.rd_n & sy.wr_n);
	wire ale_fall = ale_d & ~sy.ale;
	// address source per mux select
	wire [7:0] cur_addr = sy.mux_sel ? mux_addr : sy.addr_in;

	// --------------------------------
	// address latch
	// --------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			ale_d    <= 1'b0;
			mux_addr <= ADDR_RST;
		end else begin
			ale_d <= sy.ale;
			if (ale_fall && sy.mux_sel)
				mux_addr <= sy.data_in;
		end
	end

	// --------------------------------
	// access state machine
	// --------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (rd_start)
					next_state = ST_READ;
				else if (wr_start)
					next_state = ST_WRITE;
			end
			ST_READ: begin
				if (strobe_idle)
					next_state = ST_IDLE;
			end
			ST_WRITE: begin
				if (strobe_idle)
					next_state = ST_IDLE;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// write commits on strobe release, once the data has settled
	wire wr_commit = (state == ST_WRITE) && strobe_idle;

	always_ff @(posedge clk) begin
		if (srst) begin
			state       <= ST_IDLE;
			reg_addr    <= ADDR_RST;
			reg_wdata   <= DATA_RST;
			reg_wr      <= 1'b0;
			reg_rd      <= 1'b0;
			data_pin_o  <= DATA_RST;
			data_pin_oe <= 1'b0;
		end else begin
			state  <= next_state;
			reg_rd <= (state == ST_IDLE) && rd_start;
			reg_wr <= wr_commit;
			if (state == ST_IDLE && (rd_start || wr_start))
				reg_addr <= cur_addr;
			if (state == ST_WRITE)
				reg_wdata <= sy.data_in;
			data_pin_o  <= reg_rdata;
			data_pin_oe <= (next_state == ST_READ);
		end
	end

	// --------------------------------
	// checks
	// --------------------------------
	a_read_drive: assert property (@(posedge clk) disable iff (srst)
		(state == ST_IDLE && rd_start) |=> data_pin_oe)
		else $error("read did not drive data bus");
	a_read_pulse: assert property (@(posedge clk) disable iff (srst)
		reg_rd |-> $past(rd_start) && !$past(reg_rd))
		else $error("read pulse without strobe");
	a_write_pulse: assert property (@(posedge clk) disable iff (srst)
		reg_wr |-> $past(state) == ST_WRITE)
		else $error("write pulse outside write");
	a_write_once: assert property (@(posedge clk) disable iff (srst)
		reg_wr |=> !reg_wr)
		else $error("write pulse longer than one cycle");
	a_no_drive_write: assert property (@(posedge clk) disable iff (srst)
		(state == ST_WRITE) |=> !data_pin_oe)
		else $error("bus driven during write");
	a_release_bus: assert property (@(posedge clk) disable iff (srst)
		(state == ST_READ && strobe_idle) |=> !data_pin_oe)
		else $error("bus not released after read");
	a_mux_latch: assert property (@(posedge clk) disable iff (srst)
		(ale_fall && sy.mux_sel) |=> mux_addr == $past(sy.data_in))
		else $error("address not latched on strobe fall");
	a_addr_source: assert property (@(posedge clk) disable iff (srst)
		(state == ST_IDLE && rd_start && !sy.mux_sel) |=> reg_addr == $past(sy.addr_in))
		else $error("separate address not used");

	// --------------------------------
	// decode and sequencing checks
	// --------------------------------
	// strobe meaning in each bus format
	a_sep_read_take: assert property (@(posedge clk) disable iff (srst)
		(state == ST_IDLE && !sy.fmt_sel && sel && !sy.rd_n && sy.wr_n)
		|=> state == ST_READ)
		else $error("read strobe not taken");
	a_sep_write_take: assert property (@(posedge clk) disable iff (srst)
		(state == ST_IDLE && !sy.fmt_sel && sel && sy.rd_n && !sy.wr_n)
		|=> state == ST_WRITE)
		else $error("write strobe not taken");
	a_both_refused: assert property (@(posedge clk) disable iff (srst)
		(state == ST_IDLE && !sy.fmt_sel && !sy.rd_n && !sy.wr_n)
		|=> state == ST_IDLE)
		else $error("both strobes low was taken");
	a_dir_read_take: assert property (@(posedge clk) disable iff (srst)
		(state == ST_IDLE && sy.fmt_sel && sel && !sy.rd_n && sy.wr_n)
		|=> state == ST_READ && reg_rd)
		else $error("direction high not taken as read");
	a_dir_write_take: assert property (@(posedge clk) disable iff (srst)
		(state == ST_IDLE && sy.fmt_sel && sel && !sy.rd_n && !sy.wr_n)
		|=> state == ST_WRITE)
		else $error("direction low not taken as write");
	a_unselected_idle: assert property (@(posedge clk) disable iff (srst)
		(state == ST_IDLE && sy.chip_sel_n)
		|=> state == ST_IDLE && !reg_rd)
		else $error("access taken without chip select");

	// access end, pulses and read data
	a_write_end: assert property (@(posedge clk) disable iff (srst)
		(state == ST_WRITE && strobe_idle)
		|=> state == ST_IDLE && reg_wr)
		else $error("write not committed on release");
	a_read_end: assert property (@(posedge clk) disable iff (srst)
		(state == ST_READ && strobe_idle)
		|=> state == ST_IDLE && !reg_wr)
		else $error("read not ended on release");
	a_pulse_exclusive: assert property (@(posedge clk) disable iff (srst)
		!(reg_rd && reg_wr))
		else $error("read and write pulses together");
	a_write_data: assert property (@(posedge clk) disable iff (srst)
		reg_wr |-> reg_wdata == $past(sy.data_in))
		else $error("write data not last sample");
	a_read_data: assert property (@(posedge clk) disable iff (srst)
		!$past(srst) |-> data_pin_o == $past(reg_rdata))
		else $error("read data not one cycle behind");
	a_oe_state: assert property (@(posedge clk) disable iff (srst)
		data_pin_oe == (state == ST_READ))
		else $error("drive enable outside read");

	// address path
	a_mux_addr_use: assert property (@(posedge clk) disable iff (srst)
		(state == ST_IDLE && (rd_start || wr_start) && sy.mux_sel)
		|=> reg_addr == $past(mux_addr))
		else $error("latched address not used");
	a_addr_hold: assert property (@(posedge clk) disable iff (srst)
		(state != ST_IDLE) |=> $stable(reg_addr))
		else $error("address changed inside access");
	a_latch_hold: assert property (@(posedge clk) disable iff (srst)
		!(ale_fall && sy.mux_sel) |=> $stable(mux_addr))
		else $error("latched address changed without strobe");
	a_sep_write_addr: assert property (@(posedge clk) disable iff (srst)
		(state == ST_IDLE && wr_start && !sy.mux_sel)
		|=> reg_addr == $past(sy.addr_in))
		else $error("separate write address not used");
endmodule

// [design/pin_sync.sv]
module pin_sync (
	input  wire logic       clk,	// system clock
	input  wire logic       srst,	// sync reset
	input  wire logic [7:0] data_pin,	// data lines
	input  wire logic [7:0] addr_pin,	// address lines
	input  wire logic       cs_pin_n,	// chip select
	input  wire logic       rd_pin_n,	// read / data strobe
	input  wire logic       wr_pin_n,	// write / direction
	input  wire logic       ale_pin,	// address latch
	input  wire logic       mux_pin,	// mux select strap
	input  wire logic       fmt_pin,	// format strap
	pin_sync_if.sync        sy	// synchronised outputs
);
	// --------------------------------
	// two-stage synchroniser
	// --------------------------------
	logic [21:0] s1;
	logic [21:0] s2;
	wire  [21:0] raw = {data_pin, addr_pin, cs_pin_n, rd_pin_n, wr_pin_n, ale_pin,
		mux_pin, fmt_pin};

	// strobes idle high on reset so no false edge appears
	always_ff @(posedge clk) begin
		if (srst) begin
			s1 <= 22'h000038;	// chip select and both strobes high
			s2 <= 22'h000038;
		end else begin
			s1 <= raw;
			s2 <= s1;
		end
	end

	assign sy.data_in    = s2[21:14];
	assign sy.addr_in    = s2[13:6];
	assign sy.chip_sel_n = s2[5];
	assign sy.rd_n       = s2[4];
	assign sy.wr_n       = s2[3];
	assign sy.ale        = s2[2];
	assign sy.mux_sel    = s2[1];
	assign sy.fmt_sel    = s2[0];
endmodule

// [include/host_port_pkg.sv]
package host_port_pkg;
	// widths
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	// clock and timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int RD_LOW_MIN_NS = 160;
	localparam int WR_LOW_MIN_NS = 120;
	localparam int ALE_MIN_NS = 40;
	localparam int RD_VALID_MAX_NS = 140;
	localparam int XFER_NONMUX_NS = 260;
	localparam int XFER_MUX_NS = 300;
	// derived cycle counts (least times round up)
	localparam int RD_LOW_CYC = (RD_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_LOW_CYC = (WR_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ALE_CYC = (ALE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// longest time rounds down
	localparam int RD_VALID_CYC = RD_VALID_MAX_NS / CLK_PERIOD_NS;
	// reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
	localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
	// access states
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_WRITE = 2'b10
	} access_e;
endpackage

// [include/pin_sync_if.sv]
interface pin_sync_if;
	logic [7:0] data_in;	// synchronised data lines
	logic [7:0] addr_in;	// synchronised address lines
	logic       chip_sel_n;	// synchronised chip select
	logic       rd_n;	// read strobe or data strobe
	logic       wr_n;	// write strobe or direction
	logic       ale;	// address latch / address strobe
	logic       mux_sel;	// mux select strap
	logic       fmt_sel;	// bus format strap
	modport sync (output data_in, addr_in, chip_sel_n, rd_n, wr_n, ale, mux_sel, fmt_sel);
	modport core (input data_in, addr_in, chip_sel_n, rd_n, wr_n, ale, mux_sel, fmt_sel);
endinterface

// [testbench/host_model.sv]
module host_model (
	input  wire logic       clk,	// clock
	input  wire logic [7:0] dev_q,	// device data out
	input  wire logic       dev_oe,	// device drives
	output logic      [7:0] dq,	// data lines as seen
	output logic      [7:0] addr,	// address lines
	output logic            cs_n,	// chip select
	output logic            rd_n,	// read or data strobe
	output logic            wr_n,	// write or direction
	output logic            ale,	// latch strobe
	output logic            mux,	// mux strap
	output logic            fmt	// format strap
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] hv;
	logic       hd;
	// released lines show the inverse of the last value
	assign dq = dev_oe ? dev_q : (hd ? hv : ~hv);
	initial begin
		{cs_n, rd_n, wr_n, ale, mux, fmt, hd} = 7'h70;
		hv = 8'h00;
		addr = 8'h00;
	end
	// one byte access, strobes held 175 ns, just past the 160 ns read minimum
	task automatic xfer(input logic w, input logic [7:0] a, d, input logic sel,
		output logic [7:0] q);
		@(posedge clk);
		#2 addr = mux ? ~a : a;	// junk on unused address lines
		if (mux) begin
			hd = 1;
			hv = a;
			ale = 1;
			repeat (2) @(posedge clk);
			#2 ale = 0;
			repeat (2) @(posedge clk);
		end
		#2 hd = w;
		hv = d;
		wr_n = fmt ? !w : 1'b1;
		cs_n = !sel;
		@(posedge clk);
		#2 if (fmt || !w) rd_n = 0;
		else wr_n = 0;
		repeat (7) @(posedge clk);
		q = dq;
		#2 rd_n = 1;
		if (!fmt) wr_n = 1;
		@(posedge clk);
		#2 {hd, cs_n, wr_n} = 3'h3;
		repeat (3) @(posedge clk);
	endtask
endmodule

// [testbench/test_parallel_host_bus_port.sv]
module test_parallel_host_bus_port;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0;
	logic        srst = 1;
	logic  [7:0] dq, qo, addr, ra, wd, rdat;
	logic        oe, cs_n, rd_n, wr_n, ale, mux, fmt, rw, rr;
	logic  [7:0] mem [256];
	logic  [7:0] exp [256];
	logic [16:0] notes [$];
	int          mismatches, compares;
	always #12.5 clk = ~clk;
	assign rdat = mem[ra];
	host_model hm (.clk(clk), .dev_q(qo), .dev_oe(oe), .dq(dq), .addr(addr), .cs_n(cs_n),
		.rd_n(rd_n), .wr_n(wr_n), .ale(ale), .mux(mux), .fmt(fmt));
	parallel_host_bus_port dut (.clk(clk), .srst(srst), .data_pin_i(dq), .data_pin_o(qo),
		.data_pin_oe(oe), .addr_pin(addr), .cs_pin_n(cs_n), .rd_pin_n(rd_n),
		.wr_pin_n(wr_n), .ale_pin(ale), .mux_select_pin(mux),
		.bus_format_select_pin(fmt), .reg_addr(ra), .reg_wdata(wd), .reg_wr(rw),
		.reg_rd(rr), .reg_rdata(rdat));
	task automatic check(input logic [16:0] seen, exp_v);
		compares++;
		if (seen !== exp_v) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp_v);
		end
	endtask
	task automatic close_out;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// register side: each pulse takes the oldest note
	always @(posedge clk) begin
		#1 if (rw || rr) begin
			check({rw, ra, rw ? wd : 8'h00}, notes.size() ? notes.pop_front() : 'x);
			if (rw) mem[ra] = wd;
		end
	end
	// host access with expected results noted first
	task automatic acc(input logic w, input logic [7:0] a, d, input logic sel);
		logic [7:0] q;
		if (sel) notes.push_back({w, a, w ? d : 8'h00});
		hm.xfer(w, a, d, sel, q);
		if (!w) check({9'h000, q}, {9'h000, exp[a]});
		if (w && sel) exp[a] = d;
	endtask
	initial begin
		#100us mismatches++;
		close_out;
	end
	initial begin
		logic [7:0] a, d;
		for (int i = 0; i < 256; i++) begin
			mem[i] = i;
			exp[i] = i;
		end
		void'($urandom(32'h7da1d524));
		repeat (3) @(posedge clk);
		#2 srst = 0;
		for (int m = 0; m < 4; m++) begin
			hm.mux = m[0];
			hm.fmt = m[1];
			repeat (4) @(posedge clk);
			for (int k = 0; k < 3; k++) begin
				a = k ? $urandom : 8'hFF;
				d = $urandom;
				acc(1, a, d, 1);
				acc(0, a, 8'h00, 1);
				acc(1, a, ~d, 0);
				acc(0, a, 8'h00, 1);
			end
			$display("mode %0d done", m);
		end
		close_out;
	end
endmodule
